// file: core/usart_clk_defines.svh
// Purpose: offsets, field positions, reset values and counts for the
//          serial clock/buffer core
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   included by the package and the core
`ifndef USART_CLK_DEFINES_SVH
`define USART_CLK_DEFINES_SVH

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define OFS_DATA        32'h0000_0000
`define OFS_STAT_A      32'h0000_0004
`define OFS_CTRL_C      32'h0000_0008
`define OFS_DIV_LOW     32'h0000_000C
`define OFS_DIV_HIGH    32'h0000_0010
`define OFS_POWER       32'h0000_0014

// ---------------------------------------------------------------------
// status/control A fields
// ---------------------------------------------------------------------
`define STA_DOUBLE      0
`define STA_RX_READY    1
`define STA_TX_EMPTY    2
`define STA_FRAME_ERR   3
`define STA_OVERRUN     4
`define STA_PARITY_ERR  5
`define STA_NINTH       6
`define STA_TX_IDLE     7

// ---------------------------------------------------------------------
// control C fields
// ---------------------------------------------------------------------
`define CTC_SYNC        0
`define CTC_POL         1
`define CTC_DIR         2
`define CTC_SIZE_LO     3
`define CTC_SIZE_HI     5
`define CTC_PAR_LO      6
`define CTC_PAR_HI      7
`define CTC_TWO_STOP    8
`define CTC_TX_EN       9
`define CTC_RX_EN       10
`define CTC_TX_NINTH    11
`define CTC_WIDTH       12

// ---------------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------------
`define RST_CTRL_C      12'h000
`define RST_DIV         12'h000
`define RST_POWER       1'h0
`define OVS_NORMAL      4'hF
`define OVS_DOUBLE      4'h7
`define SIZE_NINE       3'h7
`define PAR_ODD         2'h3
`define ENTRY_W         12

`endif

// file: core/usart_clk_pkg.sv
// Purpose: types for the serial clock/buffer core
// Assumes: usart_clk_defines.svh holds all numbers
// Notes:   state of the core is one packed struct
`include "usart_clk_defines.svh"

package usart_clk_pkg;

	// -----------------------------------------------------------------
	// state machines
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_DATA   = 3'b001,
		TX_PARITY = 3'b010,
		TX_STOP1  = 3'b011,
		TX_STOP2  = 3'b100
	} tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_DATA   = 3'b001,
		RX_PARITY = 3'b010,
		RX_STOP   = 3'b011
	} rx_state_type;

	typedef logic [`ENTRY_W-1:0] entry_type;

	// -----------------------------------------------------------------
	// whole core state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
		logic [11:0]          div;
		logic [11:0]          cnt;
		logic                 dbl;
		logic [`CTC_WIDTH-1:0] ctrl;
		logic                 pwr_off;
		logic                 xck_s1;
		logic                 xck_s2;
		logic                 xck_s3;
		logic                 xck_o;
		logic                 xck_oe;
		logic                 rxd_s1;
		logic                 rxd_s2;
		tx_state_type         tx_st;
		logic [3:0]           tx_ovs;
		logic [3:0]           tx_idx;
		logic [8:0]           tx_sh;
		logic                 tx_par;
		logic                 txd;
		logic [8:0]           tbuf;
		logic                 tbuf_full;
		rx_state_type         rx_st;
		logic [3:0]           rx_ovs;
		logic [3:0]           rx_idx;
		logic [8:0]           rx_sh;
		logic                 rx_par;
		logic                 pend;
		entry_type            pend_e;
		logic                 dor_carry;
		entry_type [1:0]      fifo;
		logic                 wp;
		logic                 rp;
		logic [1:0]           fcnt;
	} core_state_type;

endpackage

// file: core/usart_clk_core.sv
// Purpose: bit-rate generator, clock modes, tx write buffer and rx fifo
//          of a serial transceiver, with an APB register slave
// Assumes: clk 100 MHz; rxd and transfer clock pin come from outside
// Notes:   one packed struct holds all state except the reset syncer
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "usart_clk_defines.svh"

// Function
// - counter reloads at zero or low write
// - one tick per counter zero
// - divisor is twelve bits, 0 to 4095
// - tx divides tick by 16/8/2
// - rx steps 16/8/2 states per bit
// - sync select; direction picks master or slave
// - clock pin used only when synchronous
// - double speed only affects asynchronous mode
// - double speed uses 8 rx samples
// - slave clock synchronised then edge detected
// - sample on edge opposite to change
// - polarity picks change and sample edges
// - rx buffer is two-entry circular fifo
// - error flags, ninth bit stored per entry
// - shift register holds third character
// - single tx buffer gives gapless frames
// - detect frame, overrun and parity errors
// - disabled while power reduction bit set
module usart_clk_core
	import usart_clk_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// serial data
	input  wire logic        rxd,
	output logic             txd,
	// transfer clock pin
	input  wire logic        transfer_clock_in,
	output logic             transfer_clock_out,
	output logic             transfer_clock_oe
);
	import usart_clk_pkg::*;

	// -----------------------------------------------------------------
	// reset release
	// -----------------------------------------------------------------
	logic rst_s1;
	logic rst_n_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1  <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1  <= 1'b1;
			rst_n_q <= rst_s1;
		end
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [3:0] char_bits(input logic [2:0] cs);
		if (cs == `SIZE_NINE)
			char_bits = 4'h9;
		else if (cs[2])
			char_bits = 4'h8;
		else
			char_bits = {1'b0, cs} + 4'h5;
	endfunction

	core_state_type s_q;
	core_state_type s_d;

	logic       setup;
	logic       wr;
	logic       rd;
	logic       div_low_wr;
	logic [11:0] load_val;
	logic       tick;
	logic       sync;
	logic       master;
	logic       slave;
	logic       rise;
	logic       fall;
	logic       chg;
	logic       smp;
	logic [3:0] ovs_max;
	logic       tx_bit;
	logic       rx_bit;
	logic [3:0] nbits;
	logic       par_on;
	logic       frame_done;
	logic       start_seen;
	logic       pop;
	logic       push;
	entry_type  new_e;
	entry_type  head;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		head = s_q.fifo[s_q.rp];
		setup = psel & ~penable & ~s_q.pready;
		wr = psel & penable & s_q.pready & pwrite;
		rd = psel & penable & s_q.pready & ~pwrite;
		div_low_wr = wr && (paddr == `OFS_DIV_LOW);
		pop = rd && (paddr == `OFS_DATA) && (s_q.fcnt != 2'h0);

		// apb: one setup, one access cycle, registered answer
		s_d.pready = setup;
		s_d.pslverr = 1'b0;
		if (setup) begin
			s_d.prdata = 32'h0000_0000;
			unique case (paddr)
				`OFS_DATA:
					s_d.prdata[7:0] = head[7:0];
				`OFS_STAT_A: begin
					s_d.prdata[`STA_DOUBLE] = s_q.dbl;
					s_d.prdata[`STA_RX_READY] = s_q.fcnt != 2'h0;
					s_d.prdata[`STA_TX_EMPTY] = ~s_q.tbuf_full;
					s_d.prdata[`STA_FRAME_ERR] = head[9];
					s_d.prdata[`STA_OVERRUN] = head[10];
					s_d.prdata[`STA_PARITY_ERR] = head[11];
					s_d.prdata[`STA_NINTH] = head[8];
					s_d.prdata[`STA_TX_IDLE] = s_q.tx_st == TX_IDLE;
				end
				`OFS_CTRL_C:
					s_d.prdata[`CTC_WIDTH-1:0] = s_q.ctrl;
				`OFS_DIV_LOW:
					s_d.prdata[7:0] = s_q.div[7:0];
				`OFS_DIV_HIGH:
					s_d.prdata[3:0] = s_q.div[11:8];
				`OFS_POWER:
					s_d.prdata[0] = s_q.pwr_off;
				default:
					s_d.pslverr = 1'b1;
			endcase
		end

		// register writes
		if (wr) begin
			unique case (paddr)
				`OFS_STAT_A:
					s_d.dbl = pwdata[`STA_DOUBLE];
				`OFS_CTRL_C:
					s_d.ctrl = pwdata[`CTC_WIDTH-1:0];
				`OFS_DIV_LOW:
					s_d.div[7:0] = pwdata[7:0];
				`OFS_DIV_HIGH:
					s_d.div[11:8] = pwdata[3:0];
				`OFS_POWER:
					s_d.pwr_off = pwdata[0];
				default: ;
			endcase
		end

		// pin synchronisers; stage one feeds stage two only
		s_d.xck_s1 = transfer_clock_in;
		s_d.xck_s2 = s_q.xck_s1;
		s_d.xck_s3 = s_q.xck_s2;
		s_d.rxd_s1 = rxd;
		s_d.rxd_s2 = s_q.rxd_s1;

		// bit-rate generator
		load_val = div_low_wr ? {s_q.div[11:8], pwdata[7:0]} : s_q.div;
		tick = (s_q.cnt == 12'h000) & ~s_q.pwr_off;
		if (s_q.pwr_off)
			s_d.cnt = s_q.div;
		else if (s_q.cnt == 12'h000 || div_low_wr)
			s_d.cnt = load_val;
		else
			s_d.cnt = s_q.cnt - 12'h001;

		// clock modes
		sync = s_q.ctrl[`CTC_SYNC];
		master = sync & s_q.ctrl[`CTC_DIR];
		slave = sync & ~s_q.ctrl[`CTC_DIR];
		s_d.xck_oe = master & ~s_q.pwr_off;
		if (master && tick)
			s_d.xck_o = ~s_q.xck_o;
		else if (!master)
			s_d.xck_o = 1'b0;
		// slave edges come from the second stage and its delayed copy
		rise = (master & tick & ~s_q.xck_o)
			| (slave & s_q.xck_s2 & ~s_q.xck_s3 & ~s_q.pwr_off);
		fall = (master & tick & s_q.xck_o)
			| (slave & ~s_q.xck_s2 & s_q.xck_s3 & ~s_q.pwr_off);
		chg = s_q.ctrl[`CTC_POL] ? fall : rise;
		smp = s_q.ctrl[`CTC_POL] ? rise : fall;
		ovs_max = s_q.dbl ? `OVS_DOUBLE : `OVS_NORMAL;

		nbits = char_bits(s_q.ctrl[`CTC_SIZE_HI:`CTC_SIZE_LO]);
		par_on = s_q.ctrl[`CTC_PAR_HI];

		// transmitter
		tx_bit = sync ? chg : (tick && s_q.tx_ovs == ovs_max);
		if (!sync && tick)
			s_d.tx_ovs = (s_q.tx_ovs == ovs_max) ? 4'h0 : s_q.tx_ovs + 4'h1;
		if (wr && paddr == `OFS_DATA) begin
			s_d.tbuf = {s_q.ctrl[`CTC_TX_NINTH], pwdata[7:0]};
			s_d.tbuf_full = 1'b1;
		end
		if (!s_q.ctrl[`CTC_TX_EN] || s_q.pwr_off) begin
			s_d.tx_st = TX_IDLE;
			s_d.txd = 1'b1;
		end else if (tx_bit) begin
			unique case (s_q.tx_st)
				TX_IDLE: begin
					// start bit straight after last stop: no gap
					if (s_q.tbuf_full) begin
						s_d.txd = 1'b0;
						s_d.tx_sh = s_q.tbuf;
						s_d.tx_idx = 4'h0;
						s_d.tx_par = s_q.ctrl[`CTC_PAR_LO];
						s_d.tx_st = TX_DATA;
						if (!(wr && paddr == `OFS_DATA))
							s_d.tbuf_full = 1'b0;
					end else begin
						s_d.txd = 1'b1;
					end
				end
				TX_DATA: begin
					s_d.txd = s_q.tx_sh[0];
					s_d.tx_par = s_q.tx_par ^ s_q.tx_sh[0];
					s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
					s_d.tx_idx = s_q.tx_idx + 4'h1;
					if (s_q.tx_idx == nbits - 4'h1)
						s_d.tx_st = par_on ? TX_PARITY : TX_STOP1;
				end
				TX_PARITY: begin
					s_d.txd = s_q.tx_par;
					s_d.tx_st = TX_STOP1;
				end
				TX_STOP1: begin
					s_d.txd = 1'b1;
					s_d.tx_st = s_q.ctrl[`CTC_TWO_STOP] ? TX_STOP2 : TX_IDLE;
				end
				TX_STOP2: begin
					s_d.txd = 1'b1;
					s_d.tx_st = TX_IDLE;
				end
				default:
					s_d.tx_st = TX_IDLE;
			endcase
		end

		// receiver: async counts ovs_max+1 ticks per bit, sync uses edges
		frame_done = 1'b0;
		start_seen = 1'b0;
		rx_bit = sync ? smp : (tick && s_q.rx_ovs == ovs_max);
		if (!s_q.ctrl[`CTC_RX_EN] || s_q.pwr_off) begin
			s_d.rx_st = RX_IDLE;
			s_d.rx_ovs = 4'h0;
		end else if (s_q.rx_st == RX_IDLE) begin
			if (sync) begin
				start_seen = smp & ~s_q.rxd_s2;
			end else if (tick) begin
				// half a bit of low line confirms the start bit
				if (s_q.rxd_s2)
					s_d.rx_ovs = 4'h0;
				else if (s_q.rx_ovs == {1'b0, ovs_max[3:1]}) begin
					start_seen = 1'b1;
					s_d.rx_ovs = 4'h0;
				end else
					s_d.rx_ovs = s_q.rx_ovs + 4'h1;
			end
			if (start_seen) begin
				s_d.rx_st = RX_DATA;
				s_d.rx_idx = 4'h0;
				s_d.rx_sh = 9'h000;
				s_d.rx_par = s_q.ctrl[`CTC_PAR_LO];
			end
		end else begin
			if (!sync && tick)
				s_d.rx_ovs = (s_q.rx_ovs == ovs_max) ? 4'h0
					: s_q.rx_ovs + 4'h1;
			if (rx_bit) begin
				unique case (s_q.rx_st)
					RX_DATA: begin
						s_d.rx_sh[s_q.rx_idx] = s_q.rxd_s2;
						s_d.rx_par = s_q.rx_par ^ s_q.rxd_s2;
						s_d.rx_idx = s_q.rx_idx + 4'h1;
						if (s_q.rx_idx == nbits - 4'h1)
							s_d.rx_st = par_on ? RX_PARITY : RX_STOP;
					end
					RX_PARITY: begin
						s_d.rx_par = s_q.rx_par ^ s_q.rxd_s2;
						s_d.rx_st = RX_STOP;
					end
					RX_STOP: begin
						frame_done = 1'b1;
						s_d.rx_st = RX_IDLE;
					end
					default:
						s_d.rx_st = RX_IDLE;
				endcase
			end
		end
		// entry: parity error, overrun, frame error, ninth bit, data
		new_e = {par_on & s_q.rx_par, s_q.dor_carry,
			~s_q.rxd_s2, s_q.rx_sh};

		// a new start while the third level is held loses it
		if (start_seen && s_q.pend) begin
			s_d.pend = 1'b0;
			s_d.dor_carry = 1'b1;
		end

		// receive fifo with shift register as third level
		push = 1'b0;
		s_d.fifo = s_q.fifo;
		if (s_q.pend && !(start_seen) && (s_q.fcnt != 2'h2 || pop)) begin
			push = 1'b1;
			s_d.fifo[s_q.wp] = s_q.pend_e;
			s_d.pend = 1'b0;
		end else if (frame_done) begin
			if (s_q.fcnt != 2'h2 || pop) begin
				push = 1'b1;
				s_d.fifo[s_q.wp] = new_e;
			end else begin
				s_d.pend = 1'b1;
				s_d.pend_e = new_e;
			end
			s_d.dor_carry = 1'b0;
		end
		if (push)
			s_d.wp = ~s_q.wp;
		if (pop)
			s_d.rp = ~s_q.rp;
		s_d.fcnt = s_q.fcnt + {1'b0, push} - {1'b0, pop};
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s_q <= '0;
			s_q.div <= `RST_DIV;
			s_q.cnt <= `RST_DIV;
			s_q.ctrl <= `RST_CTRL_C;
			s_q.pwr_off <= `RST_POWER;
			s_q.txd <= 1'b1;
			s_q.rxd_s1 <= 1'b1;
			s_q.rxd_s2 <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready = s_q.pready;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;
	assign txd = s_q.txd;
	assign transfer_clock_out = s_q.xck_o;
	assign transfer_clock_oe = s_q.xck_oe;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	property p_reload;
		tick && !div_low_wr |=> s_q.cnt == $past(s_q.div);
	endproperty
	a_reload: assert property (p_reload)
		else $error("counter did not reload at zero");

	property p_count_down;
		s_q.cnt != 12'h000 && !div_low_wr && !s_q.pwr_off
			|=> s_q.cnt == $past(s_q.cnt) - 12'h001;
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("counter did not step down");

	property p_tx_async_div;
		!sync && !s_q.dbl && tx_bit |-> s_q.tx_ovs == 4'hF;
	endproperty
	a_tx_async_div: assert property (p_tx_async_div)
		else $error("tx bit not on sixteenth tick");

	property p_pin_async;
		!sync |=> !transfer_clock_oe && !transfer_clock_out;
	endproperty
	a_pin_async: assert property (p_pin_async)
		else $error("clock pin active in async mode");

	property p_slave_edge;
		slave && !s_q.pwr_off && $rose(transfer_clock_in)
			##1 transfer_clock_in[*2] |=> $rose(s_q.xck_s3);
	endproperty
	a_slave_edge: assert property (p_slave_edge)
		else $error("slave edge not seen after two clocks");

	property p_fifo_depth;
		s_q.fcnt <= 2'h2;
	endproperty
	a_fifo_depth: assert property (p_fifo_depth)
		else $error("rx fifo over two entries");

	property p_third_level;
		frame_done && s_q.fcnt == 2'h2 && !pop && !s_q.pend |=> s_q.pend;
	endproperty
	a_third_level: assert property (p_third_level)
		else $error("third level not held");

	property p_power_off;
		s_q.pwr_off |-> !tick ##1 txd;
	endproperty
	a_power_off: assert property (p_power_off)
		else $error("active while power reduced");

	property p_master_change;
		master && tx_bit && !s_q.ctrl[`CTC_POL] |=> transfer_clock_out;
	endproperty
	a_master_change: assert property (p_master_change)
		else $error("tx change not on rising clock");

	c_back_to_back: cover property (s_q.tx_st == TX_STOP1 && tx_bit
		&& s_q.tbuf_full && !s_q.ctrl[`CTC_TWO_STOP]);
	c_third_level: cover property (s_q.pend && s_q.fcnt == 2'h2);
	c_slave_rx: cover property (slave && frame_done);
	c_double_rx: cover property (s_q.dbl && !sync && frame_done);

endmodule

// file: verification/serial_partner.sv
// Purpose: remote serial transceiver facing the clock/buffer core
// Assumes: line idles high; bit times are given in system clocks
// Notes:   slave clock idles high, so only falling-change polarity is driven
`timescale 1ns/1ps

module serial_partner (
	// clock
	input  wire logic clk,
	// serial data
	input  wire logic txd,
	output logic      rxd,
	// transfer clock pin
	input  wire logic xck_pin,
	output logic      xck_drive
);

	initial begin
		rxd = 1'b1;
		xck_drive = 1'b1;
	end

	// ----------------------------------------------
	// async frame out: start, 8 data lsb first, stop
	// ----------------------------------------------
	task automatic send(input logic [7:0] d, input int bit_t,
		input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bit_t) @(posedge clk);
		end
		// line released to its idle high level
		rxd <= 1'b1;
		repeat (bit_t) @(posedge clk);
	endtask

	// ----------------------------------------------
	// async frame in; start length needs data lsb 1
	// ----------------------------------------------
	task automatic recv(input int bit_t, output logic [7:0] d,
		output int wait_n, output int low_n);
		wait_n = 0;
		low_n = 0;
		while (txd !== 1'b0) begin
			@(posedge clk);
			wait_n++;
		end
		while (txd === 1'b0) begin
			@(posedge clk);
			low_n++;
		end
		repeat (bit_t / 2) @(posedge clk);
		d[0] = txd;
		for (int i = 1; i < 8; i++) begin
			repeat (bit_t) @(posedge clk);
			d[i] = txd;
		end
		repeat (bit_t) @(posedge clk);
	endtask

	// ----------------------------------------------
	// sync frame in, sampled on the sampling edge
	// ----------------------------------------------
	task automatic recv_sync(input logic slave, output logic [7:0] d);
		logic [15:0] s;
		int          k;
		for (int i = 0; i < 16; i++) begin
			if (slave) begin
				// period 12 clocks stays under a quarter of clk
				xck_drive <= 1'b0;
				repeat (6) @(posedge clk);
				s[i] = txd;
				xck_drive <= 1'b1;
				repeat (6) @(posedge clk);
			end else begin
				@(negedge xck_pin);
				s[i] = txd;
			end
		end
		k = 0;
		while (k < 7 && s[k] !== 1'b0)
			k++;
		d = s[k + 1 +: 8];
	endtask

endmodule

// file: verification/test_usart_clk_core.sv
// Purpose: self-checking bench for the serial clock/buffer core
// Assumes: divisor 1 or 2 keeps bit times short
// Notes:   a cycle ceiling cuts a hang short
`timescale 1ns/1ps
`include "usart_clk_defines.svh"

module test_usart_clk_core;

	logic        clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        xck_out;
	logic        xck_oe;
	logic        xck_drive;
	wire         xck_pin;
	int          n_mismatch;
	int          compares;
	int          cycles;
	logic [7:0]  got;
	int          wait_n;
	int          low_n;

	assign xck_pin = xck_oe ? xck_out : xck_drive;

	usart_clk_core DUT (
		.clk                (clk),
		.reset_n            (reset_n),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.pready             (pready),
		.prdata             (prdata),
		.pslverr            (pslverr),
		.rxd                (rxd),
		.txd                (txd),
		.transfer_clock_in  (xck_pin),
		.transfer_clock_out (xck_out),
		.transfer_clock_oe  (xck_oe)
	);

	serial_partner partner (
		.clk       (clk),
		.txd       (txd),
		.rxd       (rxd),
		.xck_pin   (xck_pin),
		.xck_drive (xck_drive)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------
	// checks and closing
	// ----------------------------------------------
	task automatic report_and_stop();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop();
		end
	end

	// ----------------------------------------------
	// apb master
	// ----------------------------------------------
	// idle cycle after each transfer keeps one assignment per time step
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, {31'h0, pready});
		@(posedge clk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input string what, input logic [31:0] a,
		input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r & mask);
	endtask

	task automatic tx_one(input logic [7:0] d, input int bit_t);
		fork
			wr(`OFS_DATA, {24'h0, d});
			partner.recv(bit_t, got, wait_n, low_n);
		join
		chk("tx byte", {24'h0, d}, {24'h0, got});
		chk("bit time", bit_t, low_n);
	endtask

	// ----------------------------------------------
	// main sequence
	// ----------------------------------------------
	initial begin
		logic [31:0] r;
		logic        e;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd("ctrl reset", `OFS_CTRL_C, 32'hFFFFFFFF, 32'h0);
		rd("div low reset", `OFS_DIV_LOW, 32'hFFFFFFFF, 32'h0);
		rd("power reset", `OFS_POWER, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 32'h00000018, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		wr(`OFS_DIV_HIGH, 32'hFFFFFFFF);
		rd("div high width", `OFS_DIV_HIGH, 32'hFFFFFFFF, 32'hF);
		wr(`OFS_DIV_HIGH, 32'h0);
		wr(`OFS_DIV_LOW, 32'h1);
		wr(`OFS_CTRL_C, 32'h618);
		chk("pin unused async", 32'h0, {31'h0, xck_oe});
		tx_one(8'h35, 32);
		fork
			begin
				wr(`OFS_DATA, 32'h35);
				// refill only once the first byte left the buffer
				do
					apb(1'b0, `OFS_STAT_A, 32'h0, r, e);
				while (r[`STA_TX_EMPTY] !== 1'b1);
				wr(`OFS_DATA, 32'hA7);
			end
			begin
				partner.recv(32, got, wait_n, low_n);
				partner.recv(32, got, wait_n, low_n);
				chk("second byte", 32'hA7, {24'h0, got});
				chk("no gap", 32'h1, {31'h0, wait_n <= 17});
			end
		join
		wr(`OFS_STAT_A, 32'h1);
		wr(`OFS_DIV_LOW, 32'h2);
		tx_one(8'h35, 24);
		wr(`OFS_STAT_A, 32'h0);
		wr(`OFS_DIV_LOW, 32'h1);
		for (int i = 1; i < 4; i++)
			partner.send(8'(i * 17), 32, 1'b1);
		rd("rx ready", `OFS_STAT_A, 32'h1A, 32'h02);
		rd("rx first", `OFS_DATA, 32'hFF, 32'h11);
		rd("rx second", `OFS_DATA, 32'hFF, 32'h22);
		rd("rx third", `OFS_DATA, 32'hFF, 32'h33);
		rd("rx empty", `OFS_STAT_A, 32'h02, 32'h0);
		for (int i = 4; i < 8; i++)
			partner.send(8'(i * 17), 32, 1'b1);
		rd("rx fourth", `OFS_DATA, 32'hFF, 32'h44);
		rd("rx clean", `OFS_STAT_A, 32'h1A, 32'h02);
		rd("rx fifth", `OFS_DATA, 32'hFF, 32'h55);
		rd("overrun flag", `OFS_STAT_A, 32'h1A, 32'h12);
		rd("rx after loss", `OFS_DATA, 32'hFF, 32'h77);
		wr(`OFS_CTRL_C, 32'h698);
		partner.send(8'h01, 32, 1'b0);
		rd("parity error", `OFS_STAT_A, 32'h3A, 32'h22);
		rd("rx parity", `OFS_DATA, 32'hFF, 32'h01);
		wr(`OFS_CTRL_C, 32'h618);
		partner.send(8'h5A, 32, 1'b0);
		rd("frame error", `OFS_STAT_A, 32'h1A, 32'h0A);
		rd("rx framed", `OFS_DATA, 32'hFF, 32'h5A);
		wr(`OFS_CTRL_C, 32'h61B);
		chk("pin input slave", 32'h0, {31'h0, xck_oe});
		wr(`OFS_DATA, 32'hC3);
		partner.recv_sync(1'b1, got);
		chk("slave byte", 32'hC3, {24'h0, got});
		wr(`OFS_CTRL_C, 32'h61D);
		// pin enable is registered one clock after the write
		@(posedge clk);
		chk("pin driven master", 32'h1, {31'h0, xck_oe});
		fork
			wr(`OFS_DATA, 32'hA7);
			partner.recv_sync(1'b0, got);
		join
		chk("master byte", 32'hA7, {24'h0, got});
		wr(`OFS_POWER, 32'h1);
		rd("power bit", `OFS_POWER, 32'h1, 32'h1);
		chk("pin off disabled", 32'h0, {31'h0, xck_oe});
		wr(`OFS_DATA, 32'h0);
		low_n = 0;
		repeat (300) begin
			@(posedge clk);
			if (txd !== 1'b1)
				low_n++;
		end
		chk("quiet disabled", 32'h0, low_n);
		report_and_stop();
	end

endmodule
